// file: inc/usb_idle_params.svh
`ifndef USB_IDLE_PARAMS_SVH
`define USB_IDLE_PARAMS_SVH

// =====================================================================
// Configuration word layout
`define CFG_AUTOGATE_BIT   0
`define CFG_SRST_BIT       1
`define CFG_WIDTH          2

// =====================================================================
// Reset values
`define AUTOGATE_RST       1'b1
`define GATE_CNT_RST       3'h0
`define SRST_CNT_RST       4'h0

// =====================================================================
// Timing counts in interconnect clock cycles
`define GATE_CYCLES        3'h4
`define SRST_CYCLES        4'h8

`endif

// file: inc/usb_idle_pkg.sv
package usb_idle_pkg;

   // =====================================================================
   // Idle handshake states
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b001,
      ST_IDLE   = 3'b010,
      ST_GATED  = 3'b100
   } idle_state_t;

endpackage

// file: rtl/soft_reset_seq.sv
`timescale 1ns/1ps
`include "usb_idle_params.svh"

module soft_reset_seq
   import usb_idle_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   // =====================================================================
   // Reset pulse stretcher
   logic       busy_q;
   logic       busy_d;
   logic       done_q;
   logic       done_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   // A start during a running reset is ignored; the reset is already
   // clearing everything the new request would clear.
   always_comb begin
      busy_d = busy_q;
      done_d = 1'b0;
      cnt_d  = cnt_q;
      if (busy_q) begin
         if (cnt_q == `SRST_CYCLES - 4'h1) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            cnt_d  = `SRST_CNT_RST;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end else if (start) begin
         busy_d = 1'b1;
         cnt_d  = `SRST_CNT_RST;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q  <= `SRST_CNT_RST;
      end else begin
         busy_q <= busy_d;
         done_q <= done_d;
         cnt_q  <= cnt_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;

endmodule

// file: rtl/usb_otg_idle_handshake_sysconfig.sv
`timescale 1ns/1ps
`include "usb_idle_params.svh"


module usb_otg_idle_handshake_sysconfig
   import usb_idle_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  idle_req,
   output logic                       idle_ack,
   input  wire logic                  iclk_on,
   input  wire logic                  bus_busy,
   input  wire logic                  reg_read,
   input  wire logic                  config_wr,
   input  wire logic [`CFG_WIDTH-1:0] config_wdata,
   input  wire logic                  legacy_keep_cfg,
   output logic                       autogate_en,
   output logic                       module_clk_run,
   output logic                       soft_reset_busy
);

   // =====================================================================
   // Software reset sequencer
   logic srst_start;
   logic srst_busy;
   logic srst_done;

   assign srst_start = config_wr && config_wdata[`CFG_SRST_BIT];

   soft_reset_seq u_srst (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (srst_start),
      .busy    (srst_busy),
      .done    (srst_done)
   );

   // =====================================================================
   // Module system configuration
   logic autogate_q;
   logic autogate_d;
   logic kept_q;
   logic kept_d;

   always_comb begin
      autogate_d = autogate_q;
      kept_d     = kept_q;
      if (srst_done) begin
         if (legacy_keep_cfg) begin
            autogate_d = kept_q;
         end else begin
            autogate_d = `AUTOGATE_RST;
         end
      end else if (config_wr && !srst_busy) begin
         if (config_wdata[`CFG_SRST_BIT]) begin
            kept_d = config_wdata[`CFG_AUTOGATE_BIT];
         end else begin
            autogate_d = config_wdata[`CFG_AUTOGATE_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         autogate_q <= `AUTOGATE_RST;
         kept_q     <= `AUTOGATE_RST;
      end else begin
         autogate_q <= autogate_d;
         kept_q     <= kept_d;
      end
   end

   // =====================================================================
   // Idle handshake
   idle_state_t state_q;
   idle_state_t state_d;
   logic [2:0]  gate_cnt_q;
   logic [2:0]  gate_cnt_d;
   logic        can_idle;

   // A switched-off interface clock means nothing can reach the module,
   // so it counts as idle whatever the activity flags say.
   assign can_idle = !iclk_on || (!bus_busy && !srst_busy);

   always_comb begin
      state_d    = state_q;
      gate_cnt_d = `GATE_CNT_RST;
      unique case (state_q)
         ST_ACTIVE: begin
            if (idle_req && can_idle) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // The gate closes only after four full cycles in idle, so a request held
            // for fewer than five cycles returns straight to active.
            if (!idle_req) begin
               state_d = ST_ACTIVE;
            end else if (autogate_q && iclk_on) begin
               if (gate_cnt_q == `GATE_CYCLES - 3'h1) begin
                  state_d = ST_GATED;
               end else begin
                  gate_cnt_d = gate_cnt_q + 3'h1;
               end
            end
         end
         ST_GATED: begin
            if (!idle_req || reg_read) begin
               state_d = ST_ACTIVE;
            end
         end
         default: begin
            state_d = ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q    <= ST_ACTIVE;
         gate_cnt_q <= `GATE_CNT_RST;
      end else begin
         state_q    <= state_d;
         gate_cnt_q <= gate_cnt_d;
      end
   end

   // The ack follows the request combinationally, so its falling edge lands in the same
   // cycle as the request edge; the rising edge does too only while can_idle is true.
   assign idle_ack = idle_req && (can_idle || state_q != ST_ACTIVE);

   assign autogate_en     = autogate_q;
   assign module_clk_run  = (state_q != ST_GATED);
   assign soft_reset_busy = srst_busy;

   // =====================================================================
   // Checks
   AST_ACK_AT_ONCE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      idle_req && !bus_busy && !srst_busy |-> idle_ack)
      else $error("Idle request with no activity was not acknowledged.");

   AST_ACK_DROP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(idle_req) |-> !idle_ack)
      else $error("Idle acknowledge stayed high after the request fell.");

   AST_GATE_NEEDS_EN: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q != ST_GATED ##1 state_q == ST_GATED |-> $past(autogate_q))
      else $error("Clock gated without the gating enable set.");

   AST_SHORT_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_IDLE && !idle_req |=> state_q == ST_ACTIVE && !module_clk_run == 1'b0)
      else $error("Short idle request did not return the module to active.");

   AST_GATE_DELAY: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_ACTIVE ##1 state_q == ST_IDLE |-> (state_q != ST_GATED) [*4])
      else $error("Clock gated earlier than four cycles after idle.");

   AST_HW_RESET: assert property (@(posedge clk_sys)
      $rose(reset_n) |-> autogate_q)
      else $error("Gating enable not 1 after hardware reset.");

   AST_SRST_RESTORE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      srst_done && !legacy_keep_cfg |=> autogate_q)
      else $error("Gating enable not 1 after software reset.");

   AST_SRST_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      srst_start && !srst_busy && legacy_keep_cfg ##9 legacy_keep_cfg
      |=> autogate_q == $past(config_wdata[`CFG_AUTOGATE_BIT], 10))
      else $error("Legacy software reset did not keep the written gating bit.");

   AST_READ_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_GATED && reg_read |=> module_clk_run)
      else $error("Register read did not restart the internal clock.");

   AST_ICLK_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
      idle_req && !iclk_on |-> idle_ack)
      else $error("Module not idle with interface clock off.");

   AST_BUSY_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      iclk_on && bus_busy && state_q == ST_ACTIVE |-> !idle_ack)
      else $error("Idle acknowledged while bus activity was in progress.");

endmodule

// file: testbench/pwr_mgr_model.sv
`timescale 1ns/1ps

// =====================================================================
// Power manager side of the idle handshake
// The request and the interface clock enable move only just after a rising edge.
// This matches a manager that runs on the same interconnect clock.
module pwr_mgr_model (
   input  wire logic clk_sys,
   output logic      idle_req,
   output logic      iclk_on
);
   initial begin
      idle_req = 1'b0;
      iclk_on  = 1'b1;
   end

   task automatic set_req(input logic v);
      @(posedge clk_sys);
      idle_req <= v;
   endtask

   task automatic set_iclk(input logic v);
      @(posedge clk_sys);
      iclk_on <= v;
   endtask
endmodule

// file: testbench/usb_otg_idle_handshake_sysconfig_tb.sv
`timescale 1ns/1ps
`include "usb_idle_params.svh"

module usb_otg_idle_handshake_sysconfig_tb;
   logic                  clk_sys;
   logic                  reset_n;
   logic                  bus_busy;
   logic                  reg_read;
   logic                  config_wr;
   logic                  legacy_keep_cfg;
   logic [`CFG_WIDTH-1:0] config_wdata;
   logic                  idle_req;
   logic                  iclk_on;
   logic                  idle_ack;
   logic                  autogate_en;
   logic                  module_clk_run;
   logic                  soft_reset_busy;
   logic [3:0]            exp_q[$];
   logic [3:0]            mask_q[$];
   logic [15:0]           lfsr_q;
   int                    error_cnt;
   int                    comparisons;

   // =====================================================================
   // Design and power manager
   usb_otg_idle_handshake_sysconfig usb_otg_idle_handshake_sysconfig_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .idle_req(idle_req), .idle_ack(idle_ack),
      .iclk_on(iclk_on), .bus_busy(bus_busy), .reg_read(reg_read), .config_wr(config_wr),
      .config_wdata(config_wdata), .legacy_keep_cfg(legacy_keep_cfg),
      .autogate_en(autogate_en), .module_clk_run(module_clk_run),
      .soft_reset_busy(soft_reset_busy));
   pwr_mgr_model pwr_mgr_model_i (.clk_sys(clk_sys), .idle_req(idle_req), .iclk_on(iclk_on));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // =====================================================================
   // Helpers
   // Status nibble is {idle_ack, autogate_en, module_clk_run, soft_reset_busy}.
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic note(input logic [3:0] m, input logic [3:0] v);
      mask_q.push_back(m);
      exp_q.push_back(v);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic cmp_status(input logic [3:0] m, input logic [3:0] v);
      logic [3:0] got;
      got = {idle_ack, autogate_en, module_clk_run, soft_reset_busy} & m;
      comparisons++;
      if (got !== (v & m)) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, v & m, got);
      end
   endtask
   // Sampling on the falling edge keeps the check clear of the launch edge.
   always @(negedge clk_sys) begin
      if (exp_q.size() > 0) cmp_status(mask_q.pop_front(), exp_q.pop_front());
   end
   task automatic cfg_write(input logic [1:0] d);
      @(posedge clk_sys);
      config_wr    <= 1'b1;
      config_wdata <= d;
      @(posedge clk_sys);
      config_wr    <= 1'b0;
   endtask
   // The second trigger at cycle 3 must be refused, so busy still ends after cycle 8.
   task automatic srst(input logic l, input logic [1:0] d, input logic ag);
      cfg_write(2'b00);
      note(4'h4, 4'h0);
      legacy_keep_cfg <= l;
      cfg_write(d);
      for (int i = 1; i <= 10; i++) begin
         if (i > 1) @(posedge clk_sys);
         if (i == 3) begin
            config_wr    <= 1'b1;
            config_wdata <= 2'b10;
         end
         if (i == 4) config_wr <= 1'b0;
         note((i == 10) ? 4'h5 : 4'h1, {1'b0, ag, 1'b0, i <= 8});
      end
   endtask
   task automatic print_verdict;
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      tick(5000);
      error_cnt++;
      print_verdict;
   end

   // =====================================================================
   // Scenarios
   initial begin
      reset_n = 1'b0; bus_busy = 1'b0; reg_read = 1'b0; config_wr = 1'b0;
      config_wdata = 2'b00; legacy_keep_cfg = 1'b0; lfsr_q = 16'h0001;
      error_cnt = 0; comparisons = 0;
      tick(2);
      reset_n <= 1'b1;
      note(4'hf, 4'h6);
      tick(1);
      bus_busy <= 1'b1;
      pwr_mgr_model_i.set_req(1'b1);
      note(4'h8, 4'h0);
      tick(1);
      bus_busy <= 1'b0;
      note(4'h8, 4'h8);
      pwr_mgr_model_i.set_req(1'b0);
      note(4'h8, 4'h0);
      pwr_mgr_model_i.set_req(1'b1);
      note(4'ha, 4'ha);
      tick(4);
      note(4'h2, 4'h2);
      tick(1);
      note(4'h2, 4'h0);
      tick(1);
      reg_read <= 1'b1;
      tick(1);
      reg_read <= 1'b0;
      note(4'ha, 4'ha);
      pwr_mgr_model_i.set_req(1'b0);
      note(4'h8, 4'h0);
      pwr_mgr_model_i.set_iclk(1'b0);
      bus_busy <= 1'b1;
      pwr_mgr_model_i.set_req(1'b1);
      note(4'h8, 4'h8);
      pwr_mgr_model_i.set_req(1'b0);
      pwr_mgr_model_i.set_iclk(1'b1);
      bus_busy <= 1'b0;
      srst(1'b0, 2'b10, 1'b1);
      srst(1'b1, 2'b10, 1'b0);
      srst(1'b1, 2'b11, 1'b1);
      legacy_keep_cfg <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         lfsr_q = lfsr_next(lfsr_q);
         pwr_mgr_model_i.set_req(1'b1);
         tick(lfsr_q % 3);
         pwr_mgr_model_i.set_req(1'b0);
         note(4'h8, 4'h0);
         // Random activity while the request is low must not disturb the handshake.
         bus_busy <= lfsr_q[0];
         reg_read <= lfsr_q[1];
         tick(6);
         bus_busy <= 1'b0;
         reg_read <= 1'b0;
         note(4'ha, 4'h2);
      end
      cfg_write(2'b00);
      pwr_mgr_model_i.set_req(1'b1);
      tick(6);
      note(4'ha, 4'ha);
      pwr_mgr_model_i.set_req(1'b0);
      tick(3);
      print_verdict;
   end
endmodule
